// File: common/osz_pkg.sv
// Constants and types for the operand and address size selector
package osz_pkg;
	// Execution modes seen by the decoder
	typedef enum logic [1:0] {OSZ_REAL, OSZ_PROT, OSZ_V86, OSZ_MGMT} osz_mode_t;

	// Register byte offsets
	localparam logic [3:0] OSZ_CTRL_OFS = 4'h0;
	localparam logic [3:0] OSZ_STAT_OFS = 4'h4;
	localparam logic [3:0] OSZ_COUNT_OFS = 4'h8;
	localparam logic [3:0] OSZ_OVR_OFS = 4'hc;

	// Control fields
	localparam int OSZ_CTRL_EN_BIT = 0;
	localparam int OSZ_CTRL_CLR_BIT = 1;
	localparam logic OSZ_CTRL_EN_RST = 1'b1;

	// Status fields
	localparam int OSZ_ST_OP32_BIT = 0;
	localparam int OSZ_ST_AD32_BIT = 1;
	localparam int OSZ_ST_SPW_BIT = 2;
	localparam int OSZ_ST_GATE_BIT = 3;
	localparam int OSZ_ST_UNR_BIT = 4;
	localparam int OSZ_ST_W = 5;

	// Offset reach
	localparam logic [31:0] OSZ_MASK16 = 32'h0000ffff;
	localparam logic [31:0] OSZ_MASK32 = 32'hffffffff;
endpackage : osz_pkg

// File: hdl/osz_select.sv
// Operand and address size selector with Wishbone register slave
`timescale 1ns/1ps
// Notes on behaviour
// - Protected mode default follows code D flag
// - Real and virtual-8086 default to 16 bits
// - Implicit stack refs use stack B flag
// - Data B flag sets expand-down upper bound
// - Gate type fixes transfer and save size
// - Operand prefix reverses default operand size
// - Address prefix reverses default address size
// - Overrides last one instruction only
// - Prefixes honoured in every mode
// - All four size combinations reachable
// - 16-bit addressing reaches first 64 KBytes
// - Explicit stack refs follow address size
// - 32-bit expand-down unreachable by 16-bit addressing
// - Stack pointer width from stack B for implicit refs only
module osz_select
	import osz_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// Instruction attributes
	input wire logic instr_valid_in,
	input wire osz_mode_t mode_in,
	input wire logic code_d_in,
	input wire logic stack_b_in,
	input wire logic data_b_in,
	input wire logic expand_down_in,
	input wire logic pfx_opsize_in,
	input wire logic pfx_addrsize_in,
	input wire logic gate_xfer_in,
	input wire logic gate_32_in,
	input wire logic implicit_stack_in,
	input wire logic [31:0] offset_in,
	// Decoded attributes
	output logic dec_valid_out,
	output logic op_size32_out,
	output logic addr_size32_out,
	output logic stack_wide_out,
	output logic save32_out,
	output logic [31:0] ea_offset_out,
	output logic [31:0] ed_upper_out,
	output logic unreachable_out,
	// Wishbone slave
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [3:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out
);

	// A prefix flips whatever default the segment chose
	function automatic logic size_flip(input logic dflt, input logic pfx);
		size_flip = dflt ^ pfx;
	endfunction : size_flip

	logic en_r;
	logic [31:0] count_r;
	logic [31:0] ovr_r;
	logic dec_valid_r;
	logic op32_r;
	logic ad32_r;
	logic spw_r;
	logic save_r;
	logic unr_r;
	logic [31:0] ea_r;
	logic [31:0] edu_r;
	logic ack_r;
	logic [31:0] rdat_r;

	// Default size from mode and code segment
	wire seg_default = (mode_in == OSZ_PROT) ? code_d_in : 1'b0;
	// Prefix only affects this instruction; nothing of it is stored
	wire op32_nxt = gate_xfer_in ? gate_32_in : size_flip(seg_default, pfx_opsize_in);
	wire ad32_nxt = size_flip(seg_default, pfx_addrsize_in);
	// Gate never changes stack pointer choice for implicit pushes
	wire spw_nxt = implicit_stack_in ? stack_b_in : ad32_nxt;
	wire [31:0] ea_nxt = ad32_nxt ? offset_in : (offset_in & OSZ_MASK16);
	wire [31:0] edu_nxt = data_b_in ? OSZ_MASK32 : OSZ_MASK16;
	wire unr_nxt = expand_down_in & data_b_in & ~ad32_nxt;
	wire take = instr_valid_in & en_r;

	// Bus decode
	wire wb_req = wb_cyc_in & wb_stb_in & ~ack_r;
	wire hit_ctrl = (wb_adr_in == OSZ_CTRL_OFS);
	wire hit_stat = (wb_adr_in == OSZ_STAT_OFS);
	wire hit_cnt = (wb_adr_in == OSZ_COUNT_OFS);
	wire hit_ovr = (wb_adr_in == OSZ_OVR_OFS);
	wire ctrl_wr = wb_req & wb_we_in & hit_ctrl & wb_sel_in[0];
	wire clr_cnt = ctrl_wr & wb_dat_in[OSZ_CTRL_CLR_BIT];
	wire [OSZ_ST_W-1:0] stat_v = {unr_r, save_r, spw_r, ad32_r, op32_r};
	wire [31:0] rdat_nxt;
	assign rdat_nxt = hit_ctrl ? {31'h0, en_r} :
		hit_stat ? {27'h0, stat_v} :
		hit_cnt ? count_r :
		hit_ovr ? ovr_r : 32'h0;

	// Next values; a clear beats a count in the same cycle
	wire any_pfx = pfx_opsize_in | pfx_addrsize_in;
	wire count_upd = clr_cnt | take;
	wire ovr_upd = clr_cnt | (take & any_pfx);
	// Counters wrap silently; software reads them as differences
	wire [31:0] count_nxt = clr_cnt ? 32'h0 : (count_r + 32'h1);
	wire [31:0] ovr_nxt = clr_cnt ? 32'h0 : (ovr_r + 32'h1);
	wire en_nxt = wb_dat_in[OSZ_CTRL_EN_BIT];
	wire ack_nxt = wb_req;
	// Read data is zero outside the ack cycle, so no stale word lingers
	wire [31:0] rdat_ack_nxt = wb_req ? rdat_nxt : 32'h0;
	// Gate type sets the saved return size; without a gate it follows operand size
	wire save_nxt = gate_xfer_in ? gate_32_in : op32_nxt;

	// Decode strobe, one cycle after the take edge
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			dec_valid_r <= 1'h0;
		end
		else
		begin
			dec_valid_r <= take;
		end
	end

	// Sizes hold until the next taken instruction
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			op32_r <= 1'h0;
		end
		else if (take)
		begin
			op32_r <= op32_nxt;
		end
	end

	// Address size kept apart from operand size
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			ad32_r <= 1'h0;
		end
		else if (take)
		begin
			ad32_r <= ad32_nxt;
		end
	end

	// Stack pointer width
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			spw_r <= 1'h0;
		end
		else if (take)
		begin
			spw_r <= spw_nxt;
		end
	end

	// Return information format
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			save_r <= 1'h0;
		end
		else if (take)
		begin
			save_r <= save_nxt;
		end
	end

	// Expand-down segment out of 16-bit reach
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			unr_r <= 1'h0;
		end
		else if (take)
		begin
			unr_r <= unr_nxt;
		end
	end

	// Effective offset after the reach mask
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			ea_r <= 32'h0;
		end
		else if (take)
		begin
			ea_r <= ea_nxt;
		end
	end

	// Expand-down upper bound
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			edu_r <= OSZ_MASK16;
		end
		else if (take)
		begin
			edu_r <= edu_nxt;
		end
	end

	// Taken instruction counter
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			count_r <= 32'h0;
		end
		else if (count_upd)
		begin
			count_r <= count_nxt;
		end
	end

	// Prefixed instruction counter
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			ovr_r <= 32'h0;
		end
		else if (ovr_upd)
		begin
			ovr_r <= ovr_nxt;
		end
	end

	// Decode enable; when low, instructions are ignored
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			en_r <= OSZ_CTRL_EN_RST;
		end
		else if (ctrl_wr)
		begin
			en_r <= en_nxt;
		end
	end

	// Ack drops after one cycle even if strobe stays high
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			ack_r <= 1'h0;
		end
		else
		begin
			ack_r <= ack_nxt;
		end
	end

	// Read data register
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			rdat_r <= 32'h0;
		end
		else
		begin
			rdat_r <= rdat_ack_nxt;
		end
	end

	assign dec_valid_out = dec_valid_r;
	assign op_size32_out = op32_r;
	assign addr_size32_out = ad32_r;
	assign stack_wide_out = spw_r;
	assign save32_out = save_r;
	assign ea_offset_out = ea_r;
	assign ed_upper_out = edu_r;
	assign unreachable_out = unr_r;
	assign wb_dat_out = rdat_r;
	assign wb_ack_out = ack_r;

endmodule : osz_select

// File: verif/osz_checker.sv
// Size selector checker
`timescale 1ns/1ps
module osz_checker import osz_pkg::*; (
	input wire logic ref_clk_in, rst_n_in, instr_valid_in, code_d_in, stack_b_in, pfx_opsize_in,
	input wire logic pfx_addrsize_in, gate_xfer_in, gate_32_in, implicit_stack_in, dec_valid_out,
	input wire logic op_size32_out, addr_size32_out, stack_wide_out, save32_out,
	input wire osz_mode_t mode_in,
	input wire logic [31:0] ea_offset_out);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	wire logic d = mode_in == OSZ_PROT & code_d_in;
	wire logic op = gate_xfer_in ? gate_32_in : d ^ pfx_opsize_in;
	wire logic ad = d ^ pfx_addrsize_in;
	a_op_size: assert property (dec_valid_out |-> op_size32_out == $past(op)) else $error("op");
	a_addr_size: assert property (dec_valid_out |-> addr_size32_out == $past(ad)) else $error("ad");
	a_stack_wide: assert property (dec_valid_out && $past(implicit_stack_in) |->
		stack_wide_out == $past(stack_b_in)) else $error("sp");
	a_explicit_stack: assert property (dec_valid_out && !$past(implicit_stack_in) |->
		stack_wide_out == addr_size32_out) else $error("ex");
	a_gate_size: assert property (dec_valid_out && $past(gate_xfer_in) |->
		save32_out == $past(gate_32_in) && op_size32_out == $past(gate_32_in)) else $error("sv");
	a_idle_quiet: assert property (!instr_valid_in |=> !dec_valid_out) else $error("dv");
	a_native_default: assert property (dec_valid_out && $past(mode_in) != OSZ_PROT |->
		addr_size32_out == $past(pfx_addrsize_in)) else $error("nd");
	a_short_reach: assert property (dec_valid_out && !addr_size32_out |->
		ea_offset_out[31:16] == 16'h0) else $error("ea");
endmodule : osz_checker
bind osz_select osz_checker chk_u (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .instr_valid_in(instr_valid_in),
	.code_d_in(code_d_in), .stack_b_in(stack_b_in), .pfx_opsize_in(pfx_opsize_in), .pfx_addrsize_in(pfx_addrsize_in),
	.gate_xfer_in(gate_xfer_in), .gate_32_in(gate_32_in), .implicit_stack_in(implicit_stack_in),
	.dec_valid_out(dec_valid_out), .op_size32_out(op_size32_out), .addr_size32_out(addr_size32_out),
	.stack_wide_out(stack_wide_out), .save32_out(save32_out), .mode_in(mode_in), .ea_offset_out(ea_offset_out));

// File: verif/osz_select_test.sv
// Size selector bench
`timescale 1ns/1ps
module osz_select_test import osz_pkg::*;;
	logic ref_clk_in = '0, rst_n_in = '0, instr_valid_in = '0, code_d_in, stack_b_in, data_b_in;
	logic expand_down_in, pfx_opsize_in, pfx_addrsize_in, gate_xfer_in, gate_32_in, implicit_stack_in;
	logic wb_cyc_in = '0, wb_stb_in = '0, wb_we_in = '0, pd, pa, po, wb_ack_out, dec_valid_out;
	logic op_size32_out, addr_size32_out, stack_wide_out, save32_out, unreachable_out;
	osz_mode_t mode_in = OSZ_REAL;
	logic [3:0] wb_adr_in = '0, wb_sel_in = 4'hf;
	logic [31:0] offset_in = '0, wb_dat_in = '0, ea_offset_out, ed_upper_out, wb_dat_out;
	logic [4:0] st;
	int failures = 0, cmp_count = 0;
	initial forever #50 ref_clk_in = ~ref_clk_in;
	osz_select dut_u (
		.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .instr_valid_in(instr_valid_in), .mode_in(mode_in),
		.code_d_in(code_d_in), .stack_b_in(stack_b_in), .data_b_in(data_b_in), .expand_down_in(expand_down_in),
		.pfx_opsize_in(pfx_opsize_in), .pfx_addrsize_in(pfx_addrsize_in), .gate_xfer_in(gate_xfer_in),
		.gate_32_in(gate_32_in), .implicit_stack_in(implicit_stack_in), .offset_in(offset_in),
		.dec_valid_out(dec_valid_out), .op_size32_out(op_size32_out), .addr_size32_out(addr_size32_out),
		.stack_wide_out(stack_wide_out), .save32_out(save32_out), .ea_offset_out(ea_offset_out),
		.ed_upper_out(ed_upper_out), .unreachable_out(unreachable_out), .wb_cyc_in(wb_cyc_in),
		.wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
		.wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out));
	task chk(string t, logic [31:0] e, g);
		cmp_count++;
		if (g !== e)
		begin
			failures++;
			$display("CHECK FAILED %s exp %h got %h", t, e, g);
		end
	endtask : chk
	task xfer(logic wr, logic [3:0] ad, logic [31:0] e);
		wb_cyc_in <= 1'h1;
		wb_stb_in <= 1'h1;
		wb_we_in <= wr;
		wb_adr_in <= ad;
		wb_sel_in <= 4'hf;
		wb_dat_in <= e;
		for (int k = 0; k < 9 && wb_ack_out !== 1'h1; k++)
			@(posedge ref_clk_in);
		wb_cyc_in <= 1'h0;
		wb_stb_in <= 1'h0;
		chk("ack", 32'h1, 32'(wb_ack_out));
		if (wb_ack_out !== 1'h1)
			results();
		if (!wr)
			chk("register", e, wb_dat_out);
		@(posedge ref_clk_in);
	endtask : xfer
	initial
	begin
		repeat (3) @(posedge ref_clk_in);
		rst_n_in <= 1'h1;
		@(posedge ref_clk_in);
		xfer(1'h0, OSZ_CTRL_OFS, 32'h1);
		for (int i = 0; i < 2048; i++)
		begin
			mode_in <= osz_mode_t'(i[10:9]);
			{code_d_in, stack_b_in, data_b_in, expand_down_in, pfx_opsize_in, pfx_addrsize_in,
				gate_xfer_in, gate_32_in, implicit_stack_in} <= i[8:0];
			offset_in <= 32'hfedc0000 | i;
			instr_valid_in <= 1'h1;
			@(posedge ref_clk_in);
			instr_valid_in <= 1'h0;
			#1;
			pd = mode_in == OSZ_PROT && code_d_in;
			pa = pd ^ pfx_addrsize_in;
			po = gate_xfer_in ? gate_32_in : pd ^ pfx_opsize_in;
			st = {expand_down_in & data_b_in & !pa, po, implicit_stack_in ? stack_b_in : pa, pa, po};
			chk("sizes", 32'({st, 1'h1}), 32'({unreachable_out, save32_out, stack_wide_out,
				addr_size32_out, op_size32_out, dec_valid_out}));
			chk("upper", data_b_in ? OSZ_MASK32 : OSZ_MASK16, ed_upper_out);
			chk("offset", pa ? offset_in : (offset_in & OSZ_MASK16), ea_offset_out);
			@(posedge ref_clk_in);
		end
		$display("decode test done");
		xfer(1'h0, OSZ_STAT_OFS, 32'(st));
		xfer(1'h0, OSZ_COUNT_OFS, 32'h800);
		xfer(1'h0, OSZ_OVR_OFS, 32'h600);
		xfer(1'h0, 4'h2, 32'h0);
		xfer(1'h1, OSZ_CTRL_OFS, 32'h3);
		xfer(1'h0, OSZ_CTRL_OFS, 32'h1);
		xfer(1'h0, OSZ_COUNT_OFS, 32'h0);
		xfer(1'h1, OSZ_CTRL_OFS, 32'h0);
		mode_in <= OSZ_PROT;
		for (int j = 0; j < 2; j++)
		begin
			instr_valid_in <= 1'h1;
			@(posedge ref_clk_in);
			instr_valid_in <= 1'h0;
			#1;
			chk("taken", 32'(j), 32'(dec_valid_out));
			@(posedge ref_clk_in);
			xfer(1'h0, OSZ_STAT_OFS, j ? 32'h1d : 32'(st));
			xfer(1'h0, OSZ_COUNT_OFS, 32'(j));
			xfer(1'h1, OSZ_CTRL_OFS, 32'h1);
		end
		$display("register test done");
		rst_n_in <= 1'h0;
		repeat (3) @(posedge ref_clk_in);
		rst_n_in <= 1'h1;
		#1;
		chk("reset upper", OSZ_MASK16, ed_upper_out);
		chk("reset offset", 32'h0, ea_offset_out);
		chk("reset sizes", 32'h0, 32'({unreachable_out, save32_out, stack_wide_out,
			addr_size32_out, op_size32_out, dec_valid_out}));
		@(posedge ref_clk_in);
		xfer(1'h0, OSZ_COUNT_OFS, 32'h0);
		xfer(1'h0, OSZ_CTRL_OFS, 32'h1);
		$display("reset test done");
		results();
	end
	task results();
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results
endmodule : osz_select_test
